/* hdl/sarif_pkg.sv */
// shared constants and types for the converter control link
package sarif_pkg;

	localparam int RESULT_W       = 12;
	localparam int CONV_EDGES     = 13;
	localparam int PWRUP_EDGES    = 14;
	localparam int CLK_PERIOD_NS  = 4;
	localparam int REF_KHZ        = 250000;

	// start must lead the conversion clock edge by this much for the short count
	localparam int SETUP_NS       = 50;
	localparam int SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_NS        = 10;
	localparam int HOLD_CYC       = (HOLD_NS / CLK_PERIOD_NS < 1) ? 1 : HOLD_NS / CLK_PERIOD_NS;
	localparam int ACQ_NS         = 350;
	localparam int ACQ_CYC        = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CW_NS          = 30;
	localparam int CW_CYC         = (CW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_NS      = 120;
	localparam int ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES    = 2;

	// conversion clock limits, kHz
	localparam int CLK_MAX_KHZ    = 8000;
	localparam int CLK_CONT_KHZ   = 6000;
	localparam int CLK_MIN_KHZ    = 100;
	localparam int HALF_STD       = (REF_KHZ + 2 * CLK_MAX_KHZ - 1) / (2 * CLK_MAX_KHZ);
	localparam int HALF_CONT      = (REF_KHZ + 2 * CLK_CONT_KHZ - 1) / (2 * CLK_CONT_KHZ);
	localparam int HALF_LIMIT     = REF_KHZ / (2 * CLK_MIN_KHZ);
	localparam int DIV_W          = 11;

	localparam logic STATUS_RST   = 1'b1;

	typedef enum logic [1:0] {
		MODE_TO_SUPPLY,
		MODE_OPEN,
		MODE_TO_GROUND
	} sarif_mode_t;

endpackage

/* hdl/sarif_link_if.sv */
// pin-level link between the converter control and its bus partner
`timescale 1ns/100ps
`default_nettype none
interface sarif_link_if
	import sarif_pkg::*;
();
	logic                convertStartN;
	logic                readN;
	logic                chipSelN;
	logic                conversionClock;
	sarif_mode_t         modeSel;
	logic                statusOut;
	logic [RESULT_W-1:0] resultBits;
	logic                resultOe;
	wire  [RESULT_W-1:0] resultBus;

	// data bus as seen by the partner; a released bus shows the inverse so a late sample shows up
	assign resultBus = resultOe ? resultBits : ~resultBits;

	modport device (
		input  convertStartN,
		input  readN,
		input  chipSelN,
		input  conversionClock,
		input  modeSel,
		output statusOut,
		output resultBits,
		output resultOe
	);

	modport host (
		output convertStartN,
		output readN,
		output chipSelN,
		output conversionClock,
		output modeSel,
		input  statusOut,
		input  resultBus
	);
endinterface
`default_nettype wire

/* hdl/sarif_device.sv */
// converter end: start decode, approximation sequence, status and result latch
`timescale 1ns/100ps
`default_nettype none
module sarif_device
	import sarif_pkg::*;
#(
	parameter int RES_W = RESULT_W
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	sarif_link_if.device          link,
	input  wire logic [RES_W-1:0] sampleCode,
	output logic      [RES_W-1:0] convResult,
	output logic                  convDone,
	output logic                  holdActive
);

	localparam logic [RES_W-1:0] MSB_MASK = {1'b1, {(RES_W-1){1'b0}}};

	logic [3:0]       pinIn;
	logic [3:0]       sync1_q;
	logic [3:0]       sync2_q;
	logic [3:0]       prev_q;
	sarif_mode_t      modeS1_q;
	sarif_mode_t      modeS2_q;

	logic             busy_q;
	logic             firstEdge_q;
	logic             contStart_q;
	logic [7:0]       sinceStart_q;
	logic [3:0]       edgeCnt_q;
	logic [RES_W-1:0] successiveApproxReg_q;
	logic [RES_W-1:0] bitPtr_q;
	logic [RES_W-1:0] held_q;
	logic             status_q;
	logic [RES_W-1:0] result_q;
	logic             resultOe_q;

	logic convLow;
	logic rdLow;
	logic csLow;
	logic convFall;
	logic rdFall;
	logic csFall;
	logic clkRise;
	logic readEvent;
	logic modeVdd;
	logic contMode;
	logic startEdge;
	logic start;
	logic early;
	logic countEdge;
	logic doneNow;
	logic [RES_W-1:0] trial;

	assign pinIn = {link.conversionClock, link.chipSelN, link.readN, link.convertStartN};

	// every pin crosses two flip-flops before use
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gSync
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					sync1_q[g] <= 1'b1;
					sync2_q[g] <= 1'b1;
					prev_q[g]  <= 1'b1;
				end else begin
					sync1_q[g] <= pinIn[g];
					sync2_q[g] <= sync1_q[g];
					prev_q[g]  <= sync2_q[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			modeS1_q <= MODE_OPEN;
			modeS2_q <= MODE_OPEN;
		end else begin
			modeS1_q <= link.modeSel;
			modeS2_q <= modeS1_q;
		end
	end

	assign convLow   = ~sync2_q[0];
	assign rdLow     = ~sync2_q[1];
	assign csLow     = ~sync2_q[2];
	assign convFall  = prev_q[0] & ~sync2_q[0];
	assign rdFall    = prev_q[1] & ~sync2_q[1];
	assign csFall    = prev_q[2] & ~sync2_q[2];
	assign clkRise   = sync2_q[3] & ~prev_q[3];
	assign readEvent = rdLow & csLow & (prev_q[1] | prev_q[2]);
	assign modeVdd   = (modeS2_q == MODE_TO_SUPPLY);
	assign contMode  = (modeS2_q == MODE_TO_GROUND) & convLow & rdLow & csLow;

	assign startEdge = convFall
		| (convLow & rdLow & csFall)
		| (convLow & csLow & rdFall);

	// a running conversion masks every start source
	assign start = ~busy_q & convLow
		& (startEdge | (contMode & clkRise));

	// late start costs one dummy clock edge
	assign early     = contStart_q | (sinceStart_q >= 8'(SETUP_CYC));
	assign countEdge = busy_q & clkRise & (~firstEdge_q | early);
	assign doneNow   = countEdge & (edgeCnt_q == 4'(CONV_EDGES - 1));
	assign trial     = successiveApproxReg_q | bitPtr_q;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q                <= 1'b0;
			firstEdge_q           <= 1'b0;
			contStart_q           <= 1'b0;
			sinceStart_q          <= 8'h00;
			edgeCnt_q             <= 4'h0;
			successiveApproxReg_q <= '0;
			bitPtr_q              <= '0;
			held_q                <= '0;
		end else if (start) begin
			busy_q                <= 1'b1;
			firstEdge_q           <= 1'b1;
			contStart_q           <= contMode & clkRise;
			sinceStart_q          <= 8'h00;
			edgeCnt_q             <= 4'h0;
			successiveApproxReg_q <= '0;
			bitPtr_q              <= MSB_MASK;
			// offset binary inside, so the compare is unsigned
			held_q                <= sampleCode ^ MSB_MASK;
		end else if (busy_q) begin
			if (sinceStart_q != 8'hFF) begin
				sinceStart_q <= sinceStart_q + 8'h01;
			end
			if (clkRise) begin
				firstEdge_q <= 1'b0;
			end
			if (countEdge) begin
				edgeCnt_q <= edgeCnt_q + 4'h1;
				bitPtr_q  <= bitPtr_q >> 1;
				if (bitPtr_q != '0 && held_q >= trial) begin
					successiveApproxReg_q <= trial;
				end
				if (doneNow) begin
					busy_q <= 1'b0;
				end
			end
		end
	end

	// track while idle, hold a short delay after start
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			holdActive <= 1'b0;
		end else begin
			holdActive <= busy_q & ~doneNow & (sinceStart_q >= 8'(HOLD_CYC - 1));
		end
	end

	// status pin: the end-of-conversion update wins over a start clear or a read set
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			status_q <= STATUS_RST;
		end else if (doneNow) begin
			status_q <= ~modeVdd;
		end else if (start && !modeVdd) begin
			status_q <= 1'b0;
		end else if (readEvent && modeVdd) begin
			status_q <= 1'b1;
		end
	end

	// result latch loads on the same cycle the status changes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			result_q   <= '0;
			convResult <= '0;
			convDone   <= 1'b0;
		end else begin
			convDone <= doneNow;
			if (doneNow) begin
				result_q   <= successiveApproxReg_q ^ MSB_MASK;
				convResult <= successiveApproxReg_q ^ MSB_MASK;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			resultOe_q <= 1'b0;
		end else begin
			resultOe_q <= rdLow & csLow;
		end
	end

	assign link.statusOut  = status_q;
	assign link.resultBits = result_q;
	assign link.resultOe   = resultOe_q;

endmodule
`default_nettype wire

/* hdl/sarif_host.sv */
// bus partner end: conversion clock, start and read strobes, result capture
`timescale 1ns/100ps
`default_nettype none
module sarif_host
	import sarif_pkg::*;
#(
	parameter int RES_W = RESULT_W
) (
	input  wire logic             ref_clk,
	input  wire logic             rstn,
	sarif_link_if.host            link,
	input  wire sarif_mode_t      modeCfg,
	input  wire logic             contRun,
	input  wire logic             convReq,
	input  wire logic             readReq,
	input  wire logic             readConvReq,
	output logic                  hostReady,
	output logic      [RES_W-1:0] dataOut,
	output logic                  dataValid,
	output logic                  convEnded
);

	typedef enum {
		ST_POWERUP,
		ST_IDLE,
		ST_LAUNCH,
		ST_STROBE,
		ST_CONVERT,
		ST_ACQUIRE,
		ST_CONT
	} sarif_hstate_t;

	sarif_hstate_t    state_q;
	logic [DIV_W-1:0] divCnt_q;
	logic [DIV_W-1:0] half;
	logic             clk_q;
	logic             convN_q;
	logic             rdN_q;
	logic             csN_q;
	logic             doConv_q;
	logic             doRead_q;
	logic [7:0]       cnt_q;
	logic [3:0]       puEdges_q;
	logic [2:0]       stSync_q;
	logic [RES_W-1:0] d1_q;
	logic [RES_W-1:0] d2_q;

	logic tick;
	logic clkFall;
	logic clkRise;
	logic contSel;
	logic stRise;
	logic stFall;
	logic endSeen;

	assign contSel = contRun & (modeCfg == MODE_TO_GROUND);
	// clock kept within its range, slower in back-to-back mode
	assign half    = contSel ? DIV_W'(HALF_CONT) : DIV_W'(HALF_STD);
	assign tick    = (divCnt_q == half - DIV_W'(1));
	assign clkFall = tick & clk_q;
	assign clkRise = tick & ~clk_q;
	assign stRise  = stSync_q[1] & ~stSync_q[2];
	assign stFall  = ~stSync_q[1] & stSync_q[2];
	assign endSeen = (modeCfg == MODE_TO_SUPPLY) ? stFall : stRise;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			divCnt_q <= '0;
			clk_q    <= 1'b0;
		end else if (tick || divCnt_q >= half) begin
			divCnt_q <= '0;
			clk_q    <= ~clk_q;
		end else begin
			divCnt_q <= divCnt_q + DIV_W'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stSync_q <= 3'h7;
			d1_q     <= '0;
			d2_q     <= '0;
		end else begin
			stSync_q <= {stSync_q[1:0], link.statusOut};
			d1_q     <= link.resultBus;
			d2_q     <= d1_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= ST_POWERUP;
			convN_q   <= 1'b1;
			rdN_q     <= 1'b1;
			csN_q     <= 1'b1;
			doConv_q  <= 1'b0;
			doRead_q  <= 1'b0;
			cnt_q     <= 8'h00;
			puEdges_q <= 4'h0;
			hostReady <= 1'b0;
			dataOut   <= '0;
			dataValid <= 1'b0;
			convEnded <= 1'b0;
		end else begin
			dataValid <= 1'b0;
			convEnded <= 1'b0;
			case (state_q)
				ST_POWERUP: begin
					// wait for tracking to begin, then a full acquisition
					if (puEdges_q != 4'(PWRUP_EDGES)) begin
						if (clkRise) begin
							puEdges_q <= puEdges_q + 4'h1;
						end
					end else if (cnt_q == 8'(ACQ_CYC)) begin
						cnt_q     <= 8'h00;
						hostReady <= 1'b1;
						state_q   <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ST_IDLE: begin
					if (contSel) begin
						convN_q   <= 1'b0;
						rdN_q     <= 1'b0;
						csN_q     <= 1'b0;
						hostReady <= 1'b0;
						state_q   <= ST_CONT;
					end else if (convReq || readReq || readConvReq) begin
						doConv_q  <= convReq | readConvReq;
						doRead_q  <= readReq | readConvReq;
						hostReady <= 1'b0;
						state_q   <= ST_LAUNCH;
					end
				end
				ST_LAUNCH: begin
					// launch on the clock fall: half a period of lead time
					if (clkFall) begin
						convN_q <= ~doConv_q;
						rdN_q   <= ~doRead_q;
						csN_q   <= ~doRead_q;
						cnt_q   <= 8'h00;
						state_q <= ST_STROBE;
					end
				end
				ST_STROBE: begin
					if (cnt_q == 8'(ACCESS_CYC + SYNC_STAGES) ||
						(!doRead_q && cnt_q == 8'(CW_CYC))) begin
						if (doRead_q) begin
							dataOut   <= d2_q;
							dataValid <= 1'b1;
						end
						convN_q <= 1'b1;
						rdN_q   <= 1'b1;
						csN_q   <= 1'b1;
						cnt_q   <= 8'h00;
						if (doConv_q) begin
							state_q <= ST_CONVERT;
						end else begin
							hostReady <= 1'b1;
							state_q   <= ST_IDLE;
						end
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ST_CONVERT: begin
					if (endSeen) begin
						convEnded <= 1'b1;
						cnt_q     <= 8'h00;
						state_q   <= ST_ACQUIRE;
					end
				end
				ST_ACQUIRE: begin
					// acquisition gap before the next start
					if (cnt_q == 8'(ACQ_CYC)) begin
						hostReady <= 1'b1;
						state_q   <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ST_CONT: begin
					// data follows the status rise in back-to-back mode
					if (stRise) begin
						dataOut   <= d2_q;
						dataValid <= 1'b1;
						convEnded <= 1'b1;
					end
					if (!contSel) begin
						convN_q <= 1'b1;
						rdN_q   <= 1'b1;
						csN_q   <= 1'b1;
						cnt_q   <= 8'h00;
						state_q <= ST_ACQUIRE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign link.conversionClock = clk_q;
	assign link.convertStartN   = convN_q;
	assign link.readN           = rdN_q;
	assign link.chipSelN        = csN_q;
	assign link.modeSel         = modeCfg;

endmodule
`default_nettype wire

/* tb/sarif_link_asserts.sv */
// concurrent checks on the converter link pins
`timescale 1ns/100ps
`default_nettype none
module sarif_link_asserts
	import sarif_pkg::*;
(
	input wire logic                ref_clk,
	input wire logic                rstn,
	input wire logic                convertStartN,
	input wire logic                readN,
	input wire logic                chipSelN,
	input wire logic                conversionClock,
	input wire sarif_mode_t         modeSel,
	input wire logic                statusOut,
	input wire logic [RESULT_W-1:0] resultBits,
	input wire logic                resultOe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	logic       busyMode;
	logic       contMode;
	logic       clkPrev_q;
	logic [4:0] riseCnt_q;
	logic [3:0] rdAge_q;
	logic [3:0] cvAge_q;

	assign busyMode = (modeSel != MODE_TO_SUPPLY);
	assign contMode = (modeSel == MODE_TO_GROUND) && !convertStartN && !readN && !chipSelN;

	// link clock rises seen while the busy flag is low
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clkPrev_q <= 1'b0;
			riseCnt_q <= 5'h00;
		end else begin
			clkPrev_q <= conversionClock;
			if (statusOut)
				riseCnt_q <= 5'h00;
			else if (conversionClock && !clkPrev_q && riseCnt_q != 5'h1F)
				riseCnt_q <= riseCnt_q + 5'h01;
		end
	end

	// cycles since a read select or a convert start was last seen low
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdAge_q <= 4'hF;
			cvAge_q <= 4'hF;
		end else begin
			rdAge_q <= (!readN && !chipSelN) ? 4'h0 : rdAge_q + {3'h0, rdAge_q != 4'hF};
			cvAge_q <= !convertStartN ? 4'h0 : cvAge_q + {3'h0, cvAge_q != 4'hF};
		end
	end

	oe_follow_a: assert property (
		$rose(resultOe) |-> !$past(readN, 2) && !$past(chipSelN, 2)) else $error("bus driven unselected");
	oe_release_a: assert property (
		(readN || chipSelN) [*5] |-> !resultOe) else $error("bus not released");
	busy_start_a: assert property (
		($fell(statusOut) && busyMode) |-> cvAge_q <= 4'h6) else $error("start without convert low");
	conv_len_a: assert property (
		($rose(statusOut) && busyMode) |-> riseCnt_q >= 5'h0C) else $error("conversion too short");
	no_restart_a: assert property (
		(!statusOut && busyMode) |-> riseCnt_q <= 5'h0E) else $error("conversion ran too long");
	hold_data_a: assert property (
		($changed(resultBits) && busyMode) |-> $rose(statusOut)) else $error("data moved mid conversion");
	int_clear_a: assert property (
		($rose(statusOut) && !busyMode) |-> rdAge_q <= 4'h6) else $error("interrupt cleared unread");
	cont_again_a: assert property (
		($rose(statusOut) && contMode) |-> ##[1:120] ($fell(statusOut) || !contMode))
		else $error("no back-to-back restart");
endmodule
`default_nettype wire

/* tb/test_sar_adc_conversion_interface.sv */
// self-checking bench: host and converter ends joined by the pin link
`timescale 1ns/100ps
`default_nettype none
module test_sar_adc_conversion_interface
	import sarif_pkg::*;
;
	logic                ref_clk, rstn, contRun, convReq, readReq, readConvReq;
	logic                convDone, holdActive, hostReady, dataValid, convEnded, holdSeen;
	logic [2:0]          reqVec;
	logic [31:0]         rnd;
	sarif_mode_t         modeCfg;
	logic [RESULT_W-1:0] sampleCode, convResult, dataOut, expCode, oldCode;
	logic [RESULT_W-1:0] corner [4];
	int                  miscompares, checked, seed, cyc, m, k, t0;

	assign {readConvReq, readReq, convReq} = reqVec;

	sarif_link_if link ();
	sarif_device i_sarif_device (.ref_clk(ref_clk), .rstn(rstn), .link(link.device),
		.sampleCode(sampleCode), .convResult(convResult), .convDone(convDone),
		.holdActive(holdActive));
	sarif_host i_sarif_host (.ref_clk(ref_clk), .rstn(rstn), .link(link.host),
		.modeCfg(modeCfg), .contRun(contRun), .convReq(convReq), .readReq(readReq),
		.readConvReq(readConvReq), .hostReady(hostReady), .dataOut(dataOut),
		.dataValid(dataValid), .convEnded(convEnded));
	sarif_link_asserts i_sarif_link_asserts (.ref_clk(ref_clk), .rstn(rstn),
		.convertStartN(link.convertStartN), .readN(link.readN), .chipSelN(link.chipSelN),
		.conversionClock(link.conversionClock), .modeSel(link.modeSel),
		.statusOut(link.statusOut), .resultBits(link.resultBits), .resultOe(link.resultOe));

	always #(CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (holdActive === 1'b1)
			holdSeen <= 1'b1;
	end

	task automatic final_report();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_code(input logic [RESULT_W-1:0] got, exp, input string what);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, exp, input string what);
		chk_code({11'h000, got}, {11'h000, exp}, what);
	endtask

	task automatic chk_num(input int got, exp, input string what);
		checked++;
		if (got != exp) begin
			miscompares++;
			$display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return hostReady;
			1: return convEnded;
			2: return dataValid;
			default: return convDone;
		endcase
	endfunction

	// status level expected once a conversion has ended
	function automatic logic exp_end_status(input sarif_mode_t mode);
		return (mode != MODE_TO_SUPPLY);
	endfunction

	// back-to-back: fourteen conversion clocks of 2 * HALF_CONT reference cycles each
	function automatic int exp_period();
		return 14 * 2 * HALF_CONT;
	endfunction

	// bounded wait for a host or device flag, sampled between edges
	task automatic wait_on(input int w);
		int n;
		n = 0;
		while (pick(w) !== 1'b1) begin
			@(negedge ref_clk);
			n++;
			if (n > 4000) begin
				miscompares++;
				$display("MISMATCH %0t wait %0d timed out", $time, w);
				final_report();
			end
		end
	endtask

	// w: 0 convert, 1 read, 2 read with convert
	task automatic request(input int w);
		wait_on(0);
		reqVec = 3'(1 << w);
		@(negedge ref_clk);
		reqVec = 3'h0;
		@(negedge ref_clk);
	endtask

	task automatic convert_and_check(input logic [RESULT_W-1:0] code, input int w);
		oldCode = expCode;
		expCode = code;
		sampleCode = code;
		holdSeen = 1'b0;
		request(w);
		if (w == 2) begin
			wait_on(2);
			chk_code(dataOut, oldCode, "rom read");
		end
		wait_on(1);
		chk_code(convResult, code, "result");
		chk_bit(holdSeen, 1'b1, "hold seen");
		chk_bit(holdActive, 1'b0, "tracking");
		chk_bit(link.statusOut, exp_end_status(modeCfg), "status at end");
		@(negedge ref_clk);
		request(1);
		wait_on(2);
		chk_code(dataOut, code, "read back");
		repeat (6) @(negedge ref_clk);
		chk_bit(link.statusOut, 1'b1, "status after read");
		chk_bit(link.resultOe, 1'b0, "bus released");
	endtask

	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		modeCfg = MODE_OPEN;
		contRun = 1'b0;
		reqVec = 3'h0;
		sampleCode = 12'h000;
		expCode = 12'h000;
		oldCode = 12'h000;
		holdSeen = 1'b0;
		miscompares = 0;
		checked = 0;
		seed = 28;
		cyc = 0;
		corner = '{12'h7FF, 12'h800, 12'h000, 12'hFFF};
		repeat (5) @(negedge ref_clk);
		rstn = 1'b1;
		for (m = 0; m < 3; m++) begin
			modeCfg = sarif_mode_t'(m);
			convert_and_check(corner[m], 0);
			for (k = 0; k < 2; k++) begin
				rnd = $random(seed);
				// read with convert first, then a plain convert; a bare read never converts
				convert_and_check(rnd[RESULT_W-1:0], 2 - 2 * k);
			end
			$display("mode %0d test done", m);
		end
		// back-to-back conversions with every strobe held low
		modeCfg = MODE_TO_GROUND;
		sampleCode = corner[3];
		contRun = 1'b1;
		wait_on(3);
		@(negedge ref_clk);
		wait_on(3);
		t0 = cyc;
		for (k = 0; k < 3; k++) begin
			@(negedge ref_clk);
			wait_on(3);
			chk_num(cyc - t0, exp_period(), "conversion period");
			t0 = cyc;
			chk_code(convResult, corner[3], "continuous result");
			chk_code(link.resultBus, corner[3], "bus always driven");
		end
		contRun = 1'b0;
		$display("continuous test done");
		final_report();
	end
endmodule
`default_nettype wire
